// *** spi_mode_pkg.sv ***
// constants, types and state records for the switch mode and serial control block
// ----------------------------------------------------------------------------
// Operation
// - before any wake the device sleeps with all logic idle and outputs off
// - normal mode only when wake is one and fail is zero
// - normal: ch1-4 follow on bit or direct input, ch5-6 on bit; rise of ch1-5 opens window
// - limp input high or serial failure forces fail mode
// - fail: outputs 1-4 follow direct inputs, 5-6 off, pwm unavailable
// - fail: writes have no effect, readback still served, analog feedback off
// - fail: maximum overcurrent profile, auto-restart on overload or undervoltage
// - fail: overtemperature, high overcurrent or severe short latches output off
// - fail: ch1-4 follow inputs, windows opened by input detect, ch5-6 off
// - wake-up clears all serial registers and masks faults for a while
// - host raises reset input; initialisation finishes after 50 us
// - normal to fail at once; input settings cleared, status kept
// - readback stays available in fail for limp, watchdog and frame errors
// - fail to normal after cause gone and toggle bit 0 then 1 in time
// - fail to normal clears registers and in the same cycle sets status and cleared flags
// - cleared flag drops on a read of the quick status register or while the device sleeps
// - 16 bit full-duplex frames, input bits emerge on output for chaining
// - input sampled and output updated on rising serial clock
// - select fall freezes the output word, first rising clock loads it, trailing edge latches frame, idle output released
// - reset input low clears serial and fault registers; high keeps device awake
// - frame: top nibble address, bit 11 toggle bit, low bits data; reset zero
// - toggle bit must change each write, else the link fails at once; watchdog timeout also fails it
// - wake is OR of input detects and reset input; fail is serial fail OR limp
// ----------------------------------------------------------------------------
package spi_mode_pkg;

	// ------------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------------
	localparam int CLK_FREQ_MHZ = 50;
	localparam int INIT_TIME_US = 50;
	localparam int INIT_CYCLES = INIT_TIME_US * CLK_FREQ_MHZ;
	localparam logic [11:0] INIT_LAST = 12'(INIT_CYCLES - 1);

	// ------------------------------------------------------------------------
	// frame layout and register map
	// ------------------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int DATA_W = 11;
	localparam int NUM_REGS = 16;
	localparam logic [3:0] REG_INIT1 = 4'h0;
	localparam logic [3:0] REG_QUICK = 4'h1;
	localparam logic [3:0] REG_CH1 = 4'h2;
	localparam logic [3:0] REG_CH5 = 4'h6;
	localparam logic [3:0] REG_DEVSTAT = 4'h7;
	localparam logic [3:0] REG_INPUT_EN = 4'hB;
	localparam logic [3:0] REG_TEST = 4'hF;
	localparam int ON_BIT = 8;
	localparam int FM_BIT = 11;
	localparam int DSF_BIT = 10;
	localparam int RCF_BIT = 6;
	localparam int SPIF_BIT = 1;
	localparam int LIMP_BIT = 0;

	// ------------------------------------------------------------------------
	// synchronised pin vector
	// ------------------------------------------------------------------------
	localparam int SYNC_W = 11;
	localparam int SY_CS = 0;
	localparam int SY_LIMP = 1;
	localparam int SY_RST = 2;
	localparam int SY_INON = 3;
	localparam int SY_DIR = 7;

	localparam int WD_CNT_W = 24;
	localparam int MASK_CNT_W = 16;
	localparam int RESTART_CNT_W = 20;

	typedef enum logic [1:0] {
		MODE_SLEEP = 2'h0,
		MODE_NORMAL = 2'h1,
		MODE_FAIL = 2'h2
	} mode_t;

	typedef struct packed {
		logic [3:0] addr;
		logic wd;
		logic [DATA_W-1:0] data;
	} frame_t;

	typedef struct packed {
		logic [FRAME_BITS-1:0] sh;
		logic [4:0] cnt;
		logic so;
	} link_t;

	typedef struct packed {
		logic [NUM_REGS-1:0][DATA_W-1:0] mem;
		logic [DATA_W-1:0] rd;
	} regfile_t;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		logic [SYNC_W-1:0] st;
		mode_t mode;
		logic [11:0] initCnt;
		logic initDone;
		logic [MASK_CNT_W-1:0] maskCnt;
		logic [WD_CNT_W-1:0] wdCnt;
		logic wdLast;
		logic spiFail;
		logic recov;
		logic [4:0] lastCnt;
		logic [FRAME_BITS-1:0] txWord;
		logic [3:0] frameAddr;
		logic registers_cleared_flag;
		logic device_status_flag;
		logic [3:0] latchOff;
		logic [3:0][RESTART_CNT_W-1:0] restart;
		logic [5:0] chPrev;
		logic [3:0] inOnPrev;
		logic [5:0] pwr;
		logic [4:0] ocStart;
		logic soOeN;
		logic pwmEn;
		logic senseEn;
		logic maxOc;
		logic faultMask;
	} core_t;

	// synchronisers start at the idle select level so no false select edge follows reset
	localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(1) << SY_CS;
	localparam core_t CORE_RST = '{s1: SYNC_IDLE, s2: SYNC_IDLE, s3: SYNC_IDLE, st: SYNC_IDLE,
		soOeN: 1'b1, mode: MODE_SLEEP, default: '0};

endpackage

// *** spi_reg_file.sv ***
// serial input register storage with clear, one write port and a registered read port
`timescale 1ns/100ps
module spi_reg_file (
	input wire logic clk, // core clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic ce, // clock enable
	input wire logic clr, // clear every register
	input wire logic we, // write strobe
	input wire logic [3:0] waddr, // write address
	input wire logic [spi_mode_pkg::DATA_W-1:0] wdata, // write data
	input wire logic [3:0] raddr, // read address
	output logic [spi_mode_pkg::DATA_W-1:0] rdata, // registered read data
	output logic [spi_mode_pkg::NUM_REGS-1:0][spi_mode_pkg::DATA_W-1:0] words // all registers
);
	spi_mode_pkg::regfile_t r_q;
	spi_mode_pkg::regfile_t r_d;

	always_comb begin
		r_d = r_q;
		if (clr) begin
			r_d.mem = '0;
		end else if (we) begin
			r_d.mem[waddr] = wdata;
		end
		r_d.rd = r_d.mem[raddr];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_q <= '0;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	assign rdata = r_q.rd;
	assign words = r_q.mem;
endmodule

// *** switch_mode_spi.sv ***
// operating mode sequencer, channel routing and serial control interface
`timescale 1ns/100ps
module switch_mode_spi #(
	parameter logic [spi_mode_pkg::WD_CNT_W-1:0] WD_TIMEOUT_CYCLES = 24'h2625A0,
	parameter logic [spi_mode_pkg::MASK_CNT_W-1:0] FAULT_MASK_CYCLES = 16'h03E8,
	parameter logic [spi_mode_pkg::RESTART_CNT_W-1:0] RESTART_CYCLES = 20'h0C350
) (
	input wire logic clk, // core clock, 50 MHz
	input wire logic rst_n, // reset, active low; synchronous in the core, asynchronous on the serial link
	input wire logic ce, // clock enable
	input wire logic sclk, // serial clock from host
	input wire logic chipSelectLow, // serial select, active low
	input wire logic si, // serial data in
	output logic soOut, // serial data out
	output logic soOeN, // serial out enable, low while driving
	input wire logic resetInputLow, // reset pin level, low resets
	input wire logic [3:0] inputOnDetect, // wake detect inputs
	input wire logic [3:0] directInput, // direct control inputs
	input wire logic limpHomeInput, // limp home request
	input wire logic [3:0] overTemp, // overtemperature per channel
	input wire logic [3:0] severeShort, // severe short per channel
	input wire logic highOvercurrentDetect1, // high overcurrent on channel 1
	input wire logic [3:0] overload, // overload per channel
	input wire logic underVoltage, // supply undervoltage
	input wire logic [4:0][6:0] chStatus, // channel status bits for readback
	output logic [5:0] powerOutput, // channel drive commands
	output logic [4:0] ocWindowStart, // overcurrent window start pulses
	output logic pwmEnable, // pwm module available
	output logic senseEnable, // analog feedback available
	output logic maxOcProfile, // maximum overcurrent profile active
	output logic faultMask, // fault reporting masked
	output logic [1:0] opMode, // operating mode
	output logic spiFailFlag // serial failure latched
);
	spi_mode_pkg::core_t c_q;
	spi_mode_pkg::core_t c_d;
	spi_mode_pkg::link_t lk_q;
	spi_mode_pkg::link_t lk_d;
	logic firstEdge_q;
	logic [spi_mode_pkg::DATA_W-1:0] rdata;
	logic [spi_mode_pkg::NUM_REGS-1:0][spi_mode_pkg::DATA_W-1:0] words;
	logic rfClr;
	logic rfWe;
	spi_mode_pkg::frame_t rx;
	logic [4:0] diff;
	logic csRise;
	logic csFall;
	logic wakeNow;
	logic frameIn;
	logic mod16Err;
	logic goodFrame;
	logic toggled;
	logic wdTimeout;
	logic spiEvt;
	logic rcfRead;
	logic limp;
	logic rstIn;
	logic [3:0] inOn;
	logic [3:0] dirIn;
	logic [5:0] chan;
	logic [3:0] soa;
	logic [15:0] soWord;

	// ------------------------------------------------------------------------
	// link side, runs on the serial clock
	// ------------------------------------------------------------------------
	// marks the first edge of a frame; set by select going high, cleared by the first serial clock edge
	always_ff @(posedge sclk or posedge chipSelectLow) begin
		if (chipSelectLow) begin
			firstEdge_q <= 1'b1;
		end else begin
			firstEdge_q <= 1'b0;
		end
	end

	always_comb begin
		lk_d = lk_q;
		if (!chipSelectLow) begin
			lk_d.cnt = lk_q.cnt + 5'h01;
			if (firstEdge_q) begin
				lk_d.so = c_q.txWord[spi_mode_pkg::FRAME_BITS-1];
				lk_d.sh = {c_q.txWord[spi_mode_pkg::FRAME_BITS-2:0], si};
			end else begin
				lk_d.so = lk_q.sh[spi_mode_pkg::FRAME_BITS-1];
				lk_d.sh = {lk_q.sh[spi_mode_pkg::FRAME_BITS-2:0], si};
			end
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// ------------------------------------------------------------------------
	// serial input registers
	// ------------------------------------------------------------------------
	spi_reg_file u_regs (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.clr(rfClr),
		.we(rfWe),
		.waddr(rx.addr),
		.wdata(rx.data),
		.raddr(spi_mode_pkg::REG_INIT1),
		.rdata(rdata),
		.words(words)
	);

	// ------------------------------------------------------------------------
	// core side
	// ------------------------------------------------------------------------
	always_comb begin
		c_d = c_q;
		rfClr = 1'b0;
		rfWe = 1'b0;
		chan = '0;
		soWord = '0;
		c_d.s1 = {directInput, inputOnDetect, resetInputLow, limpHomeInput, chipSelectLow};
		c_d.s2 = c_q.s1;
		c_d.s3 = c_q.s2;
		for (int i = 0; i < spi_mode_pkg::SYNC_W; i++) begin
			if (c_q.s2[i] == c_q.s3[i]) begin
				c_d.st[i] = c_q.s3[i];
			end
		end
		limp = c_q.st[spi_mode_pkg::SY_LIMP];
		rstIn = c_q.st[spi_mode_pkg::SY_RST];
		inOn = c_q.st[spi_mode_pkg::SY_INON +: 4];
		dirIn = c_q.st[spi_mode_pkg::SY_DIR +: 4];
		wakeNow = (|inOn) | rstIn;
		csRise = c_d.st[spi_mode_pkg::SY_CS] & ~c_q.st[spi_mode_pkg::SY_CS];
		csFall = ~c_d.st[spi_mode_pkg::SY_CS] & c_q.st[spi_mode_pkg::SY_CS];
		rx = spi_mode_pkg::frame_t'(lk_q.sh);
		diff = lk_q.cnt - c_q.lastCnt;
		frameIn = csRise && (diff != 5'h00);
		mod16Err = frameIn && (diff[3:0] != 4'h0);
		goodFrame = frameIn && !mod16Err;
		toggled = rx.wd != c_q.wdLast;
		wdTimeout = c_q.wdCnt >= (WD_TIMEOUT_CYCLES - 24'h000001);
		rcfRead = goodFrame && (c_q.frameAddr == spi_mode_pkg::REG_QUICK);
		spiEvt = 1'b0;
		if (csRise) begin
			c_d.lastCnt = lk_q.cnt;
		end
		if (csFall) begin
			c_d.frameAddr = c_q.txWord[15:12];
		end
		if (rcfRead) begin
			c_d.registers_cleared_flag = 1'b0;
			c_d.device_status_flag = 1'b0;
		end
		if (!wakeNow) begin
			c_d.mode = spi_mode_pkg::MODE_SLEEP;
			c_d.initDone = 1'b0;
			c_d.spiFail = 1'b0;
			c_d.recov = 1'b0;
			c_d.latchOff = '0;
			c_d.registers_cleared_flag = 1'b0;
			c_d.device_status_flag = 1'b0;
			rfClr = 1'b1;
		end else if (c_q.mode == spi_mode_pkg::MODE_SLEEP) begin
			rfClr = 1'b1;
			c_d.mode = limp ? spi_mode_pkg::MODE_FAIL : spi_mode_pkg::MODE_NORMAL;
			c_d.initCnt = '0;
			c_d.initDone = 1'b0;
			c_d.maskCnt = FAULT_MASK_CYCLES;
			c_d.latchOff = '0;
			c_d.wdLast = 1'b1;
			c_d.wdCnt = '0;
			c_d.registers_cleared_flag = 1'b0;
			c_d.device_status_flag = 1'b0;
		end else begin
			if (!c_q.initDone) begin
				c_d.initCnt = c_q.initCnt + 12'h001;
				c_d.initDone = c_q.initCnt == spi_mode_pkg::INIT_LAST;
			end
			if (c_q.maskCnt != '0) begin
				c_d.maskCnt = c_q.maskCnt - 16'h0001;
			end
			if (!rstIn) begin
				rfClr = 1'b1;
				c_d.latchOff = '0;
			end
			if (c_q.initDone && (c_q.mode == spi_mode_pkg::MODE_NORMAL || c_q.recov)) begin
				c_d.wdCnt = c_q.wdCnt + 24'h000001;
			end
			if (c_q.mode == spi_mode_pkg::MODE_NORMAL) begin
				if (goodFrame && c_q.initDone && toggled) begin
					rfWe = rstIn && (rx.addr != spi_mode_pkg::REG_TEST);
					c_d.wdLast = rx.wd;
					c_d.wdCnt = '0;
				end
				spiEvt = c_q.initDone && (mod16Err || (goodFrame && !toggled) || wdTimeout);
				if (spiEvt) begin
					c_d.spiFail = 1'b1;
				end
				if (spiEvt || limp) begin
					c_d.mode = spi_mode_pkg::MODE_FAIL;
					rfClr = 1'b1;
					c_d.recov = 1'b0;
				end
			end else begin
				if (limp || mod16Err || (c_q.recov && wdTimeout)) begin
					c_d.recov = 1'b0;
				end else if (goodFrame && !rx.wd) begin
					c_d.recov = 1'b1;
					c_d.wdCnt = '0;
				end else if (goodFrame && rx.wd && c_q.recov) begin
					c_d.mode = spi_mode_pkg::MODE_NORMAL;
					c_d.spiFail = 1'b0;
					c_d.recov = 1'b0;
					c_d.wdLast = 1'b1;
					c_d.wdCnt = '0;
					rfClr = 1'b1;
					c_d.registers_cleared_flag = 1'b1;
					c_d.device_status_flag = 1'b1;
				end
			end
		end

		// channel routing
		if (c_d.mode == spi_mode_pkg::MODE_NORMAL && c_d.initDone) begin
			for (int i = 0; i < 6; i++) begin
				if (i < 4 && words[spi_mode_pkg::REG_INPUT_EN][2*i]) begin
					chan[i] = dirIn[i];
				end else begin
					chan[i] = words[spi_mode_pkg::REG_CH1 + 4'(i)][spi_mode_pkg::ON_BIT];
				end
			end
			c_d.ocStart = chan[4:0] & ~c_q.chPrev[4:0];
		end else if (c_d.mode == spi_mode_pkg::MODE_FAIL) begin
			for (int i = 0; i < 4; i++) begin
				if (!c_q.faultMask && (overTemp[i] || severeShort[i] ||
					(i == 0 && highOvercurrentDetect1))) begin
					c_d.latchOff[i] = 1'b1;
				end
				if (overload[i] || underVoltage) begin
					c_d.restart[i] = RESTART_CYCLES;
				end else if (c_q.restart[i] != '0) begin
					c_d.restart[i] = c_q.restart[i] - 20'h00001;
				end
				chan[i] = dirIn[i] && !c_d.latchOff[i] && (c_d.restart[i] == '0);
			end
			c_d.ocStart = {1'b0, inOn & ~c_q.inOnPrev};
		end else begin
			c_d.ocStart = '0;
		end
		c_d.pwr = chan;
		c_d.chPrev = chan;
		c_d.inOnPrev = inOn;
		c_d.pwmEn = c_d.mode == spi_mode_pkg::MODE_NORMAL && c_d.initDone;
		c_d.senseEn = c_d.mode == spi_mode_pkg::MODE_NORMAL && c_d.initDone;
		c_d.maxOc = c_d.mode == spi_mode_pkg::MODE_FAIL;
		c_d.faultMask = c_d.maskCnt != '0;
		c_d.soOeN = c_q.st[spi_mode_pkg::SY_CS] || c_q.mode == spi_mode_pkg::MODE_SLEEP;

		// readback word, refreshed only between frames
		soa = rdata[3:0];
		soWord[15:12] = soa;
		soWord[spi_mode_pkg::FM_BIT] = c_q.mode == spi_mode_pkg::MODE_FAIL;
		if (soa != spi_mode_pkg::REG_INIT1 && soa <= spi_mode_pkg::REG_DEVSTAT) begin
			soWord[spi_mode_pkg::DSF_BIT] = c_q.device_status_flag;
		end
		if (soa == spi_mode_pkg::REG_QUICK) begin
			soWord[spi_mode_pkg::RCF_BIT] = c_q.registers_cleared_flag;
		end else if (soa == spi_mode_pkg::REG_DEVSTAT) begin
			soWord[spi_mode_pkg::SPIF_BIT] = c_q.spiFail;
			soWord[spi_mode_pkg::LIMP_BIT] = limp;
		end else if (soa >= spi_mode_pkg::REG_CH1 && soa <= spi_mode_pkg::REG_CH5) begin
			soWord[6:0] = chStatus[3'(soa - spi_mode_pkg::REG_CH1)] & ~{7{c_q.faultMask}};
		end
		if (c_q.st[spi_mode_pkg::SY_CS]) begin
			c_d.txWord = soWord;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			c_q <= spi_mode_pkg::CORE_RST;
		end else if (ce) begin
			c_q <= c_d;
		end
	end

	assign soOut = lk_q.so;
	assign soOeN = c_q.soOeN;
	assign powerOutput = c_q.pwr;
	assign ocWindowStart = c_q.ocStart;
	assign pwmEnable = c_q.pwmEn;
	assign senseEnable = c_q.senseEn;
	assign maxOcProfile = c_q.maxOc;
	assign faultMask = c_q.faultMask;
	assign opMode = c_q.mode;
	assign spiFailFlag = c_q.spiFail;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n || !ce);

	AST_SLEEP_OFF: assert property (
		c_q.mode == spi_mode_pkg::MODE_SLEEP |-> powerOutput == 6'h00 && !pwmEnable)
		else $error("outputs active in sleep");
	AST_NORMAL_WAKE: assert property (
		c_q.mode == spi_mode_pkg::MODE_NORMAL |-> !c_q.spiFail && $past(wakeNow))
		else $error("normal mode without wake or with fail");
	AST_LIMP_FAIL: assert property (
		(limp && wakeNow && c_q.mode != spi_mode_pkg::MODE_SLEEP) |=>
		c_q.mode == spi_mode_pkg::MODE_FAIL)
		else $error("limp did not force fail mode");
	AST_FAIL_OUTS: assert property (
		c_q.mode == spi_mode_pkg::MODE_FAIL |->
		powerOutput[5:4] == 2'h0 && (powerOutput[3:0] & ~$past(dirIn)) == 4'h0 && !pwmEnable)
		else $error("fail mode output not following direct input");
	AST_FAIL_NO_SENSE: assert property (
		c_q.mode == spi_mode_pkg::MODE_FAIL |-> !senseEnable && maxOcProfile)
		else $error("analog feedback or profile wrong in fail");
	AST_LATCH_OFF: assert property (
		c_q.mode == spi_mode_pkg::MODE_FAIL |-> (powerOutput[3:0] & c_q.latchOff) == 4'h0)
		else $error("latched channel still driven");
	AST_WAKE_MASK: assert property (
		$past(c_q.mode) == spi_mode_pkg::MODE_SLEEP && c_q.mode != spi_mode_pkg::MODE_SLEEP
		|-> faultMask && !c_q.initDone)
		else $error("wake-up without fault masking");
	AST_INIT_TIME: assert property (
		$rose(c_q.initDone) |-> $past(c_q.initCnt) == spi_mode_pkg::INIT_LAST)
		else $error("initialisation length wrong");
	AST_RECOVER_FLAGS: assert property (
		$past(c_q.mode) == spi_mode_pkg::MODE_FAIL && c_q.mode == spi_mode_pkg::MODE_NORMAL
		|-> c_q.registers_cleared_flag && c_q.device_status_flag && !c_q.spiFail)
		else $error("recovery flags not set");
	AST_RCF_CLEAR: assert property (
		$fell(c_q.registers_cleared_flag) && c_q.mode != spi_mode_pkg::MODE_SLEEP
		&& $past(c_q.mode) != spi_mode_pkg::MODE_SLEEP |-> $past(rcfRead))
		else $error("cleared flag dropped without quick status read");
	AST_WD_TIMEOUT: assert property (
		c_q.mode == spi_mode_pkg::MODE_NORMAL && c_q.initDone && wdTimeout
		|=> c_q.mode != spi_mode_pkg::MODE_NORMAL)
		else $error("watchdog timeout ignored");
	AST_MOD16: assert property (
		c_q.mode == spi_mode_pkg::MODE_NORMAL && c_q.initDone && mod16Err |=> c_q.spiFail)
		else $error("frame length error not flagged");
endmodule

// *** host_model.sv ***
// host serial master model that sends frames and captures the device output
`timescale 1ns/100ps
module host_model (
	output logic sclk, // serial clock, still outside frames
	output logic chipSelectLow, // select, active low
	output logic si, // serial data to device
	input wire logic soOut, // serial data from device
	input wire logic soOeN // device output enable, low while driving
);
	logic last = 1'b0;
	initial begin
		sclk = 1'b0;
		chipSelectLow = 1'b1;
		si = 1'b1;
	end
	// n clock edges, msb first; a released output reads as the inverse of the last bit
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = '0;
		chipSelectLow = 1'b0;
		#120;
		for (int i = 0; i < n; i++) begin
			si = tx[15 - (i % 16)];
			#16 sclk = 1'b1;
			#16 sclk = 1'b0;
			last = soOeN ? ~last : soOut;
			rx = {rx[14:0], last};
		end
		#16 chipSelectLow = 1'b1;
		si = ~si;
		#120;
	endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the mode sequencer and serial control block
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {logic [3:0] addr; logic [10:0] data; logic [5:0] pwr;} row_t;
	localparam int WD_CYC = 4000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic resetInputLow = 1'b0;
	logic limpHomeInput = 1'b0;
	logic wdBit = 1'b0;
	logic [3:0] inputOnDetect = 4'h0;
	logic [3:0] directInput = 4'h0;
	logic [3:0] overTemp = 4'h0;
	logic [3:0] overload = 4'h0;
	logic ce = 1'b1;
	logic [4:0][6:0] chStatus = 35'h0;
	wire logic sclk, chipSelectLow, si, soOut, soOeN;
	logic [5:0] powerOutput;
	logic [4:0] ocWindowStart;
	logic [4:0] ocSeen = 5'h00;
	logic pwmEnable, senseEnable, maxOcProfile, faultMask, spiFailFlag;
	logic maskSeen = 1'b0;
	logic [1:0] opMode;
	logic [15:0] rx;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	row_t rows [7] = '{'{4'h2, 11'h100, 6'h01}, '{4'h3, 11'h100, 6'h03},
		'{4'h6, 11'h100, 6'h13}, '{4'h7, 11'h100, 6'h33},
		'{4'h2, 11'h000, 6'h32}, '{4'h6, 11'h000, 6'h22}, '{4'hB, 11'h004, 6'h20}};
	host_model host (.sclk(sclk), .chipSelectLow(chipSelectLow), .si(si), .soOut(soOut),
		.soOeN(soOeN));
	switch_mode_spi #(.WD_TIMEOUT_CYCLES(24'(WD_CYC)), .FAULT_MASK_CYCLES(16'h0014),
		.RESTART_CYCLES(20'h00032)) dut (.clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk),
		.chipSelectLow(chipSelectLow), .si(si), .soOut(soOut), .soOeN(soOeN),
		.resetInputLow(resetInputLow), .inputOnDetect(inputOnDetect),
		.directInput(directInput), .limpHomeInput(limpHomeInput), .overTemp(overTemp),
		.severeShort(4'h0), .highOvercurrentDetect1(1'b0), .overload(overload),
		.underVoltage(1'b0), .chStatus(chStatus), .powerOutput(powerOutput),
		.ocWindowStart(ocWindowStart), .pwmEnable(pwmEnable), .senseEnable(senseEnable),
		.maxOcProfile(maxOcProfile), .faultMask(faultMask), .opMode(opMode),
		.spiFailFlag(spiFailFlag));
	// ------------------------------------------------------------------------
	// clock, watchers and tasks
	// ------------------------------------------------------------------------
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		ocSeen <= ocSeen | ocWindowStart;
		maskSeen <= maskSeen | faultMask;
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [10:0] d);
		host.xfer({a, wdBit, d}, 16, rx);
		wdBit = ~wdBit;
		idle(8);
	endtask
	task automatic recover();
		wdBit = 1'b0;
		wr(spi_mode_pkg::REG_INIT1, 11'h001);
		wr(spi_mode_pkg::REG_INIT1, 11'h001);
		chk("recovered mode", 2'h1, opMode);
	endtask
	task automatic close_out();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------------
	initial begin
		idle(4);
		chk("reset mode", 2'h0, opMode);
		chk("reset so enable", 1'b1, soOeN);
		rst_n = 1'b1;
		idle(200);
		chk("sleep mode", 2'h0, opMode);
		chk("sleep outputs", 6'h00, powerOutput);
		$display("test sleep done");
		resetInputLow = 1'b1;
		idle(spi_mode_pkg::INIT_CYCLES + 20);
		chk("wake mode", 2'h1, opMode);
		chk("wake mask", 1'b1, maskSeen);
		chk("pwm on", 1'b1, pwmEnable);
		for (int i = 0; i < 7; i++) begin
			wr(rows[i].addr, rows[i].data);
			chk("row outputs", rows[i].pwr, powerOutput);
		end
		chk("window starts", 5'h13, ocSeen);
		$display("test rows done");
		ce = 1'b0;
		directInput = 4'hA;
		limpHomeInput = 1'b1;
		idle(10);
		chk("frozen mode", 2'h1, opMode);
		ce = 1'b1;
		idle(10);
		chk("limp mode", 2'h2, opMode);
		chk("fail outputs", 6'h0A, powerOutput);
		chk("fail profile", 3'h4, {maxOcProfile, pwmEnable, senseEnable});
		inputOnDetect = 4'h4;
		idle(8);
		chk("fail window", 5'h17, ocSeen);
		wr(spi_mode_pkg::REG_CH5, 11'h100);
		chk("fail write", 6'h0A, powerOutput);
		overTemp = 4'h2;
		idle(3);
		overTemp = 4'h0;
		idle(5);
		chk("latched off", 6'h08, powerOutput);
		overload = 4'h8;
		idle(3);
		overload = 4'h0;
		idle(5);
		chk("restart off", 6'h00, powerOutput);
		idle(60);
		chk("restart on", 6'h08, powerOutput);
		$display("test fail done");
		limpHomeInput = 1'b0;
		idle(10);
		recover();
		chk("cleared outputs", 6'h00, powerOutput);
		wr(spi_mode_pkg::REG_INIT1, 11'h001);
		wr(spi_mode_pkg::REG_INIT1, 11'h001);
		chk("flags set", 2'h3, {rx[spi_mode_pkg::RCF_BIT], rx[spi_mode_pkg::DSF_BIT]});
		wr(spi_mode_pkg::REG_INIT1, 11'h001);
		chk("flag cleared", 1'b0, rx[spi_mode_pkg::RCF_BIT]);
		$display("test recovery done");
		host.xfer({spi_mode_pkg::REG_INIT1, wdBit, 11'h001}, 8, rx);
		idle(10);
		chk("short frame", 3'h5, {opMode, spiFailFlag});
		recover();
		idle(WD_CYC + 20);
		chk("watchdog", 3'h5, {opMode, spiFailFlag});
		$display("test serial failure done");
		close_out();
	end
endmodule
